// >>> timers_pkg.sv
// constants, register map and carrier types for the timer, sleep and watchdog block.
// assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
package timers_pkg;
	// register byte offsets
	localparam logic [4:0] TIMER_MODE_ADDR = 5'h00;
	localparam logic [4:0] PRESCALE_A_ADDR = 5'h04;
	localparam logic [4:0] COUNTER_A_ADDR = 5'h08;
	localparam logic [4:0] PRESCALE_B_ADDR = 5'h0c;
	localparam logic [4:0] COUNTER_B_ADDR = 5'h10;
	localparam logic [4:0] OPCODE_ADDR = 5'h14;
	localparam logic [4:0] PORT_TWO_MODE_ADDR = 5'h18;
	// timer_mode_reg fields
	localparam int LOAD_A_BIT = 0;
	localparam int RUN_A_BIT = 1;
	localparam int LOAD_B_BIT = 2;
	localparam int RUN_B_BIT = 3;
	localparam int PIN_MODE_LSB = 4;
	localparam int PIN_MODE_MSB = 5;
	localparam int B_EXT_BIT = 6;
	// prescaler register fields
	localparam int CONT_BIT = 0;
	localparam int DIV_LSB = 2;
	localparam int DIV_MSB = 7;
	// opcodes
	localparam logic [7:0] OP_REFRESH = 8'h5f;
	localparam logic [7:0] OP_HALT_RUN = 8'h4f;
	localparam logic [7:0] OP_HALT = 8'h7f;
	localparam logic [7:0] OP_STOP = 8'h6f;
	// reset values and vectors
	localparam logic [7:0] PORT_TWO_MODE_RST = 8'hff;
	localparam logic [15:0] RESTART_VECTOR = 16'h000c;
	// timing
	localparam int SYS_CLK_MHZ = 20;
	localparam int POR_DELAY_US = 1000;
	localparam int POR_DELAY_CYC_DEF = POR_DELAY_US * SYS_CLK_MHZ;
	localparam int RESET_EXTRA_CYC = 18;
	localparam logic [15:0] WD_PERIOD_TICKS = 16'h0400;
	localparam logic [1:0] TCLK_LAST = 2'h3;
	// synchronised pin indices
	localparam int PIN_TIMER = 0;
	localparam int PIN_WAKE = 1;
	localparam int PIN_WD_OSC = 2;
	localparam int PIN_PERM = 3;
	localparam int PIN_COUNT = 4;

	typedef enum logic [1:0] {
		PIN_EXT_CLOCK = 2'b00,
		PIN_GATE = 2'b01,
		PIN_TRIG_ONCE = 2'b10,
		PIN_TRIG_RETRIG = 2'b11
	} pin_mode_type;

	typedef struct packed {
		logic [5:0] pre_div;
		logic continuous;
		logic [7:0] init;
	} timer_cfg_type;

	typedef struct packed {
		logic running;
		logic eoc;
		logic [5:0] pre;
		logic [7:0] cnt;
	} timer_state_type;

	typedef struct packed {
		logic zero;
		logic sign;
		logic overflow;
	} core_flags_type;
endpackage

// >>> timers_sleep_and_watchdog.sv
// two prescaled down-counters, HALT/STOP sleep control and a watchdog with reset sequencer.
// assumes the core writes opcodes to the opcode register as it executes them and
// reports an enabled pending interrupt on wake_irq; pins arrive unsynchronised.
`timescale 1ns/10ps
module timers_sleep_and_watchdog
	import timers_pkg::*;
#(
	parameter int POR_DELAY_CYCLES = POR_DELAY_CYC_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// pins and option strap
	input wire logic timer_input_pin,
	input wire logic stop_wake_pin,
	input wire logic wd_osc_clk,
	input wire logic permanent_wd_option,
	// core side
	input wire logic wake_irq,
	output logic timer_a_interrupt,
	output logic timer_b_interrupt,
	output logic cpu_clk_run,
	output logic osc_run,
	output logic core_reset,
	output logic [15:0] restart_addr,
	output logic flag_load,
	output core_flags_type flag_value,
	output logic [7:0] port_two_mode
);
	localparam logic [31:0] RESET_TOTAL = 32'(POR_DELAY_CYCLES + RESET_EXTRA_CYC);
	localparam logic [5:0] PRE_ONE = 6'h01;
	localparam logic [7:0] CNT_ONE = 8'h01;

	// one prescaler/counter step; a divisor or start value of zero means 64 or 256
	function automatic timer_state_type timer_step(timer_state_type s, timer_cfg_type c,
		logic tick);
		timer_state_type n;
		n = s;
		n.eoc = 1'b0;
		if (s.running && tick) begin
			if (s.pre == PRE_ONE) begin
				n.pre = c.pre_div;
				if (s.cnt == CNT_ONE) begin
					n.eoc = 1'b1;
					n.cnt = c.continuous ? c.init : 8'h00;
					n.running = c.continuous;
				end else begin
					n.cnt = s.cnt - CNT_ONE;
				end
			end else begin
				n.pre = s.pre - PRE_ONE;
			end
		end
		return n;
	endfunction

	// restart from the programmed initial value
	function automatic timer_state_type timer_load(timer_state_type s, timer_cfg_type c);
		timer_state_type n;
		n = s;
		n.eoc = 1'b0;
		n.pre = c.pre_div;
		n.cnt = c.init;
		return n;
	endfunction
	// avalon handshake state
	logic wait_r;
	logic [31:0] rdata_r;
	// timer state
	timer_cfg_type cfg_a_r;
	timer_cfg_type cfg_b_r;
	timer_state_type ta_r;
	timer_state_type tb_r;
	pin_mode_type pin_mode_r;
	logic b_ext_r;
	logic armed_b_r;
	logic [1:0] tclk_div_r;
	// synchronisers and filtered levels
	logic [PIN_COUNT-1:0] sync1_r;
	logic [PIN_COUNT-1:0] sync2_r;
	logic [PIN_COUNT-1:0] sync3_r;
	logic [PIN_COUNT-1:0] stable_r;
	logic [PIN_COUNT-1:0] stable_prev_r;
	// sleep, watchdog and reset sequencer
	logic halt_r;
	logic stop_r;
	logic wd_en_r;
	logic wd_halt_run_r;
	logic perm_r;
	logic [15:0] wd_cnt_r;
	logic [31:0] seq_cnt_r;
	logic core_reset_r;
	logic cpu_clk_run_r;
	logic osc_run_r;
	logic flag_load_r;
	core_flags_type flags_r;
	logic [7:0] port_two_mode_r;
	logic [15:0] restart_addr_r;
	// bus decode
	logic wr_go;
	logic [7:0] wbyte;
	logic wr_mode;
	logic wr_op;
	assign wr_go = avs_write && !wait_r && avs_byteenable[0];
	assign wbyte = avs_writedata[7:0];
	assign wr_mode = wr_go && (avs_address == TIMER_MODE_ADDR);
	assign wr_op = wr_go && (avs_address == OPCODE_ADDR) && !core_reset_r;
	// pin events taken from the agreed level, never from the first stage
	logic tclk_tick;
	logic pin_fall;
	logic wd_tick;
	logic wake_low;
	assign tclk_tick = (tclk_div_r == TCLK_LAST) && !stop_r;
	assign pin_fall = stable_prev_r[PIN_TIMER] && !stable_r[PIN_TIMER];
	assign wd_tick = !stable_prev_r[PIN_WD_OSC] && stable_r[PIN_WD_OSC];
	assign wake_low = stop_r && !stable_r[PIN_WAKE];
	// counter_b clock qualification by pin mode
	logic tick_b;
	logic trig_b;
	always_comb begin
		tick_b = tclk_tick;
		trig_b = 1'b0;
		if (b_ext_r) begin
			unique case (pin_mode_r)
				PIN_EXT_CLOCK: tick_b = pin_fall && !stop_r;
				PIN_GATE: tick_b = tclk_tick && stable_r[PIN_TIMER];
				PIN_TRIG_ONCE: trig_b = pin_fall && armed_b_r && !tb_r.running;
				PIN_TRIG_RETRIG: trig_b = pin_fall && armed_b_r;
			endcase
		end
	end
	// watchdog timing and reset causes
	logic wd_counting;
	logic wd_timeout;
	logic seq_start;
	assign wd_counting = wd_en_r && !core_reset_r && (perm_r
		|| (!stop_r && (!halt_r || wd_halt_run_r)));
	assign wd_timeout = wd_counting && wd_tick && !(wr_op && (wbyte == OP_REFRESH))
		&& (wd_cnt_r == WD_PERIOD_TICKS - 16'h0001);
	assign seq_start = wd_timeout || wake_low;
	// avalon slave: one wait cycle, read data latched while waitrequest drops
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wait_r <= 1'b1;
		end else if ((avs_read || avs_write) && wait_r) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= 1'b1;
		end
	end
	// read mux; prescalers read as zero, unmapped offsets read as zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_r <= 32'h0000_0000;
		end else if (avs_read && wait_r) begin
			rdata_r <= 32'h0000_0000;
			unique case (avs_address)
				TIMER_MODE_ADDR: rdata_r[7:0] <= {1'b0, b_ext_r, pin_mode_r,
					tb_r.running, 1'b0, ta_r.running, 1'b0};
				COUNTER_A_ADDR: rdata_r[7:0] <= ta_r.cnt;
				COUNTER_B_ADDR: rdata_r[7:0] <= tb_r.cnt;
				OPCODE_ADDR: rdata_r[7:0] <= {1'b0, flags_r, perm_r, halt_r,
					wd_halt_run_r, wd_en_r};
				PORT_TWO_MODE_ADDR: rdata_r[7:0] <= port_two_mode_r;
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end
	// three-stage synchronisers; a level counts once stages two and three agree
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_r <= '1;
			sync2_r <= '1;
			sync3_r <= '1;
			stable_r <= '1;
			stable_prev_r <= '1;
		end else begin
			sync1_r <= {permanent_wd_option, wd_osc_clk, stop_wake_pin, timer_input_pin};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			for (int i = 0; i < PIN_COUNT; i++) begin
				if (sync2_r[i] == sync3_r[i]) begin
					stable_r[i] <= sync3_r[i];
				end
			end
			stable_prev_r <= stable_r;
		end
	end
	// timer clock: system clock divided by four, frozen with the oscillator in STOP
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tclk_div_r <= 2'h0;
		end else if (!stop_r) begin
			tclk_div_r <= tclk_div_r + 2'h1;
		end
	end
	// timer configuration; prescaler and start values are write-only latches
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_a_r <= '0;
			cfg_b_r <= '0;
			pin_mode_r <= PIN_EXT_CLOCK;
			b_ext_r <= 1'b0;
		end else if (core_reset_r) begin
			cfg_a_r <= '0;
			cfg_b_r <= '0;
			pin_mode_r <= PIN_EXT_CLOCK;
			b_ext_r <= 1'b0;
		end else if (wr_go) begin
			unique case (avs_address)
				TIMER_MODE_ADDR: begin
					pin_mode_r <= pin_mode_type'(wbyte[PIN_MODE_MSB:PIN_MODE_LSB]);
					b_ext_r <= wbyte[B_EXT_BIT];
				end
				PRESCALE_A_ADDR: begin
					cfg_a_r.pre_div <= wbyte[DIV_MSB:DIV_LSB];
					cfg_a_r.continuous <= wbyte[CONT_BIT];
				end
				PRESCALE_B_ADDR: begin
					cfg_b_r.pre_div <= wbyte[DIV_MSB:DIV_LSB];
					cfg_b_r.continuous <= wbyte[CONT_BIT];
				end
				COUNTER_A_ADDR: cfg_a_r.init <= wbyte;
				COUNTER_B_ADDR: cfg_b_r.init <= wbyte;
				default: ;
			endcase
		end
	end
	// counter_a runs from the internal clock only; counts on through HALT
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ta_r <= '0;
		end else if (core_reset_r) begin
			ta_r <= '0;
		end else if (wr_mode) begin
			ta_r <= wbyte[LOAD_A_BIT] ? timer_load(ta_r, cfg_a_r) : timer_step(ta_r, cfg_a_r,
				1'b0);
			ta_r.running <= wbyte[RUN_A_BIT];
		end else begin
			ta_r <= timer_step(ta_r, cfg_a_r, tclk_tick);
		end
	end
	// counter_b; in trigger modes a run request only arms it and the pin starts it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tb_r <= '0;
			armed_b_r <= 1'b0;
		end else if (core_reset_r) begin
			tb_r <= '0;
			armed_b_r <= 1'b0;
		end else if (wr_mode) begin
			tb_r <= wbyte[LOAD_B_BIT] ? timer_load(tb_r, cfg_b_r) : timer_step(tb_r, cfg_b_r,
				1'b0);
			armed_b_r <= wbyte[RUN_B_BIT];
			tb_r.running <= wbyte[RUN_B_BIT] && !(wbyte[B_EXT_BIT]
				&& wbyte[PIN_MODE_MSB]);
		end else if (trig_b) begin
			tb_r <= timer_load(tb_r, cfg_b_r);
			tb_r.running <= 1'b1;
		end else begin
			tb_r <= timer_step(tb_r, cfg_b_r, tick_b);
		end
	end
	// HALT: core clock off until the core reports an enabled pending interrupt
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			halt_r <= 1'b0;
		end else if (core_reset_r || seq_start) begin
			halt_r <= 1'b0;
		end else if (halt_r && wake_irq) begin
			halt_r <= 1'b0;
		end else if (wr_op && (wbyte == OP_HALT)) begin
			halt_r <= 1'b1;
		end
	end
	// STOP: clock and oscillator off; only the wake pin or a permanent watchdog ends it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stop_r <= 1'b0;
		end else if (core_reset_r || seq_start) begin
			stop_r <= 1'b0;
		end else if (wr_op && (wbyte == OP_STOP)) begin
			stop_r <= 1'b1;
		end
	end
	// clock controls and restart vector; a reset cause drops the core clock with core_reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cpu_clk_run_r <= 1'b0;
			osc_run_r <= 1'b1;
			restart_addr_r <= RESTART_VECTOR;
		end else begin
			cpu_clk_run_r <= !halt_r && !stop_r && !core_reset_r && !seq_start;
			osc_run_r <= !stop_r;
			restart_addr_r <= RESTART_VECTOR;
		end
	end
	// permanent option is sampled only while the reset sequence holds the core
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			perm_r <= 1'b0;
		end else if (core_reset_r) begin
			perm_r <= stable_r[PIN_PERM];
		end
	end
	// watchdog enables; nothing but a reset can take an enabled watchdog down
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wd_en_r <= 1'b0;
			wd_halt_run_r <= 1'b0;
		end else if (core_reset_r) begin
			wd_en_r <= perm_r;
			wd_halt_run_r <= 1'b0;
		end else if (wr_op && (wbyte == OP_REFRESH)) begin
			wd_en_r <= 1'b1;
		end else if (wr_op && (wbyte == OP_HALT_RUN) && wd_en_r) begin
			wd_halt_run_r <= 1'b1;
		end
	end
	// watchdog counter on the rc oscillator edges; refresh beats a tick in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wd_cnt_r <= 16'h0000;
		end else if (core_reset_r || wd_timeout) begin
			wd_cnt_r <= 16'h0000;
		end else if (wr_op && (wbyte == OP_REFRESH)) begin
			wd_cnt_r <= 16'h0000;
		end else if (wd_counting && wd_tick) begin
			wd_cnt_r <= wd_cnt_r + 16'h0001;
		end
	end
	// reset sequencer: power-on delay plus the extra oscillator cycles, for every cause
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			core_reset_r <= 1'b1;
			seq_cnt_r <= 32'h0000_0000;
		end else if (seq_start) begin
			core_reset_r <= 1'b1;
			seq_cnt_r <= 32'h0000_0000;
		end else if (core_reset_r) begin
			if (seq_cnt_r == RESET_TOTAL - 32'h0000_0001) begin
				core_reset_r <= 1'b0;
			end
			seq_cnt_r <= seq_cnt_r + 32'h0000_0001;
		end
	end
	// core flags written by the refresh opcode, with a load strobe to the core
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags_r <= '0;
			flag_load_r <= 1'b0;
		end else begin
			flag_load_r <= wr_op && (wbyte == OP_REFRESH);
			if (wr_op && (wbyte == OP_REFRESH)) begin
				flags_r.zero <= 1'b1;
				flags_r.sign <= 1'b0;
				flags_r.overflow <= 1'b0;
			end
		end
	end
	// port mode survives a pin wake so driven outputs do not glitch
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			port_two_mode_r <= PORT_TWO_MODE_RST;
		end else if (wd_timeout) begin
			port_two_mode_r <= PORT_TWO_MODE_RST;
		end else if (wr_go && (avs_address == PORT_TWO_MODE_ADDR)) begin
			port_two_mode_r <= wbyte;
		end
	end
	// outputs straight from flip-flops
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign timer_a_interrupt = ta_r.eoc;
	assign timer_b_interrupt = tb_r.eoc;
	assign cpu_clk_run = cpu_clk_run_r;
	assign osc_run = osc_run_r;
	assign core_reset = core_reset_r;
	assign restart_addr = restart_addr_r;
	assign flag_load = flag_load_r;
	assign flag_value = flags_r;
	assign port_two_mode = port_two_mode_r;
endmodule

// >>> timers_sleep_and_watchdog_properties.sv
// port assertions for the timer, sleep and watchdog block.
// assumes one clock domain and the one-wait-cycle bus of the block.
`timescale 1ns/10ps
module timers_sleep_and_watchdog_properties
	import timers_pkg::*;
#(
	parameter int POR_DELAY_CYCLES = POR_DELAY_CYC_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// bus
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	// core side
	input wire logic wake_irq,
	input wire logic timer_a_interrupt,
	input wire logic cpu_clk_run,
	input wire logic osc_run,
	input wire logic core_reset,
	input wire logic [15:0] restart_addr,
	input wire logic flag_load,
	input wire core_flags_type flag_value
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// an opcode write the block takes; ignored while the core is held in reset
	sequence op_taken(logic [7:0] op);
		avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == OPCODE_ADDR
			&& avs_writedata[7:0] == op && !core_reset;
	endsequence
	sequence req_first;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	bus_answer_a: assert property (req_first |=> !avs_waitrequest)
		else $error("bus answer late");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	irq_gap_a: assert property (timer_a_interrupt |=> !timer_a_interrupt [*3])
		else $error("timer pulses closer than one tick");
	flag_set_a: assert property (op_taken(OP_REFRESH) |=> flag_load && flag_value == 3'b100)
		else $error("refresh flags wrong");
	flag_cause_a: assert property (flag_load |-> $past(avs_writedata[7:0]) == OP_REFRESH)
		else $error("flag load without refresh");
	// wake_irq low keeps the halt in force, so the core clock must be off
	halt_clk_a: assert property (op_taken(OP_HALT) ##1 !wake_irq [*3] |-> !cpu_clk_run)
		else $error("core clock runs in halt");
	stop_osc_a: assert property (op_taken(OP_STOP) |-> ##3 !osc_run)
		else $error("oscillator runs in stop");
	stop_exit_a: assert property ($rose(osc_run) |-> ##[0:1] core_reset)
		else $error("stop left without reset");
	restart_vec_a: assert property (restart_addr == RESTART_VECTOR)
		else $error("restart address wrong");
	reset_hold_a: assert property ($rose(core_reset) |-> core_reset [*8])
		else $error("reset pulse too short");
	reset_clk_a: assert property (core_reset |-> !cpu_clk_run)
		else $error("core clock runs in reset");
endmodule
bind timers_sleep_and_watchdog timers_sleep_and_watchdog_properties #(
	.POR_DELAY_CYCLES(POR_DELAY_CYCLES)
) i_timers_sleep_and_watchdog_properties (
	.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest), .wake_irq(wake_irq),
	.timer_a_interrupt(timer_a_interrupt), .cpu_clk_run(cpu_clk_run), .osc_run(osc_run),
	.core_reset(core_reset), .restart_addr(restart_addr), .flag_load(flag_load),
	.flag_value(flag_value)
);

// >>> core_model.sv
// stand-in for the processor core: keeps a timer request pending while halted.
// assumes interrupts arrive as one-cycle pulses and are always enabled.
`timescale 1ns/10ps
module core_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// from the block
	input wire logic timer_a_interrupt,
	input wire logic timer_b_interrupt,
	input wire logic cpu_clk_run,
	input wire logic core_reset,
	// to the block
	output logic wake_irq
);
	logic pending_r;
	// serviced as soon as the core clock runs again, so a pulse is never lost in halt
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pending_r <= 1'b0;
		end else if (core_reset || cpu_clk_run) begin
			pending_r <= 1'b0;
		end else if (timer_a_interrupt || timer_b_interrupt) begin
			pending_r <= 1'b1;
		end
	end
	assign wake_irq = pending_r;
endmodule

// >>> timers_sleep_and_watchdog_tb.sv
// self-checking bench for the timer, sleep and watchdog block.
// assumes a 20 MHz clock and a shortened power-on delay.
`timescale 1ns/10ps
module timers_sleep_and_watchdog_tb;
	import timers_pkg::*;
	localparam int POR = 20;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic timer_input_pin = 1'b1;
	logic stop_wake_pin = 1'b1;
	logic wd_osc_clk = 1'b0;
	logic wd_run = 1'b0;
	logic perm_opt = 1'b0;
	logic [31:0] avs_readdata, q, q2;
	logic avs_waitrequest, wake_irq, timer_a_interrupt, timer_b_interrupt;
	logic cpu_clk_run, osc_run, core_reset, flag_load;
	logic [15:0] restart_addr;
	core_flags_type flag_value;
	logic [7:0] port_two_mode;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int n, nv, dv;
	timers_sleep_and_watchdog #(.POR_DELAY_CYCLES(POR)) i_timers_sleep_and_watchdog (
		.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.timer_input_pin(timer_input_pin), .stop_wake_pin(stop_wake_pin),
		.wd_osc_clk(wd_osc_clk), .permanent_wd_option(perm_opt), .wake_irq(wake_irq),
		.timer_a_interrupt(timer_a_interrupt), .timer_b_interrupt(timer_b_interrupt),
		.cpu_clk_run(cpu_clk_run), .osc_run(osc_run), .core_reset(core_reset),
		.restart_addr(restart_addr), .flag_load(flag_load), .flag_value(flag_value),
		.port_two_mode(port_two_mode)
	);
	core_model i_core_model (
		.sys_clk(sys_clk), .rst(rst), .timer_a_interrupt(timer_a_interrupt),
		.timer_b_interrupt(timer_b_interrupt), .cpu_clk_run(cpu_clk_run),
		.core_reset(core_reset), .wake_irq(wake_irq)
	);
	// system clock and a slower rc oscillator of unrelated phase, about 8.4 cycles a tick
	always #25 sys_clk = ~sys_clk;
	always #210 wd_osc_clk = wd_run & ~wd_osc_clk;
	// cycles of one full count, zero fields meaning their maximum
	function automatic int span(int nn, int dd);
		return 4 * (nn == 0 ? 256 : nn) * (dd == 0 ? 64 : dd);
	endfunction
	function automatic logic seen(int s);
		case (s)
			0: return timer_a_interrupt;
			1: return timer_b_interrupt;
			2: return core_reset;
			3: return ~core_reset;
			default: return cpu_clk_run;
		endcase
	endfunction
	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one bus transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= 4'h1;
		avs_write <= w;
		avs_read <= ~w;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [4:0] a);
		bus(1'b0, a, 8'h00);
	endtask
	// bounded wait for a watched condition; n holds the cycles taken
	task automatic hold(input int s, input int lim);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (seen(s) !== 1'b1 && n < lim);
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			close_out;
		end
	end
	initial begin
		q = $urandom(32'h0170712a);
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		hold(3, 100);
		chk(n >= POR + 18 && n <= POR + 20, 1'b1);
		rd(PORT_TWO_MODE_ADDR);
		chk(q, 32'hff);
		wr(OPCODE_ADDR, OP_HALT_RUN);
		rd(OPCODE_ADDR);
		chk(q, 32'h0);
		rd(5'h1c);
		chk(q, 32'h0);
		// single pass on counter_a: slowest prescale, longest count, then random
		for (int i = 0; i < 3; i++) begin
			nv = (i == 0) ? 1 : (i == 1) ? 0 : 1 + $urandom % 8;
			dv = (i == 0) ? 0 : (i == 1) ? 1 : 1 + $urandom % 8;
			wr(PRESCALE_A_ADDR, 8'(dv << 2));
			wr(COUNTER_A_ADDR, 8'(nv));
			wr(TIMER_MODE_ADDR, 8'h03);
			hold(0, 2000);
			chk(n >= span(nv, dv) - 3 && n <= span(nv, dv) + 2, 1'b1);
			rd(COUNTER_A_ADDR);
			chk(q, 32'h0);
			rd(TIMER_MODE_ADDR);
			chk(q, 32'h0);
		end
		// continuous counter_b: exact period, then stop, read and resume
		nv = 1 + $urandom % 4;
		dv = 1 + $urandom % 3;
		wr(PRESCALE_B_ADDR, 8'(dv << 2 | 1));
		wr(COUNTER_B_ADDR, 8'(nv));
		wr(TIMER_MODE_ADDR, 8'h0c);
		hold(1, 500);
		hold(1, 500);
		chk(n, span(nv, dv));
		wr(TIMER_MODE_ADDR, 8'h00);
		rd(COUNTER_B_ADDR);
		q2 = q;
		rd(COUNTER_B_ADDR);
		chk(q, q2);
		wr(TIMER_MODE_ADDR, 8'h08);
		hold(1, 500);
		chk(n <= span(nv, dv) + 2, 1'b1);
		// every pin mode: one low pulse on the pin must end in one interrupt
		wr(PRESCALE_B_ADDR, 8'h04);
		for (int md = 0; md < 4; md++) begin
			wr(COUNTER_B_ADDR, 8'h01);
			wr(TIMER_MODE_ADDR, 8'(8'h4c | (md << 4)));
			timer_input_pin <= 1'b0;
			hold(1, 12);
			timer_input_pin <= 1'b1;
			if (timer_b_interrupt !== 1'b1) hold(1, 60);
			chk(timer_b_interrupt, 1'b1);
		end
		// halt with counter_a running; its interrupt must wake the core
		wr(PRESCALE_A_ADDR, 8'h04);
		wr(COUNTER_A_ADDR, 8'h10);
		wr(TIMER_MODE_ADDR, 8'h03);
		wr(OPCODE_ADDR, 8'hff);
		wr(OPCODE_ADDR, OP_HALT);
		repeat (3) @(posedge sys_clk);
		chk({osc_run, cpu_clk_run}, 2'b10);
		hold(0, 200);
		chk(timer_a_interrupt, 1'b1);
		hold(4, 10);
		chk(cpu_clk_run, 1'b1);
		// watchdog: enable, keep refreshing, then let it run out
		wr(OPCODE_ADDR, OP_REFRESH);
		rd(OPCODE_ADDR);
		chk(q, 32'h41);
		chk(flag_value, 32'h4);
		wd_run <= 1'b1;
		repeat (3) begin
			repeat (4000) @(posedge sys_clk);
			wr(OPCODE_ADDR, OP_REFRESH);
		end
		chk(core_reset, 1'b0);
		wr(PORT_TWO_MODE_ADDR, 8'h5a);
		hold(2, 9500);
		chk(n >= 8400 && core_reset, 1'b1);
		hold(3, 100);
		rd(PORT_TWO_MODE_ADDR);
		chk(q, 32'hff);
		rd(OPCODE_ADDR);
		chk(port_two_mode, 32'hff);
		// core flags are not part of the reset, so the refresh result stays visible
		chk(q, 32'h40);
		// stop with the watchdog enabled, well past its period, then wake by pin
		wr(OPCODE_ADDR, OP_REFRESH);
		wr(PORT_TWO_MODE_ADDR, 8'h5a);
		wr(OPCODE_ADDR, 8'hff);
		wr(OPCODE_ADDR, OP_STOP);
		repeat (10000) @(posedge sys_clk);
		chk({osc_run, cpu_clk_run, core_reset}, 3'b000);
		stop_wake_pin <= 1'b0;
		hold(2, 20);
		stop_wake_pin <= 1'b1;
		chk(core_reset, 1'b1);
		hold(3, 100);
		rd(PORT_TWO_MODE_ADDR);
		chk(q, 32'h5a);
		chk(port_two_mode, 32'h5a);
		chk(restart_addr, RESTART_VECTOR);
		// permanent strap through a second reset: on from reset and running on in STOP
		perm_opt <= 1'b1;
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		hold(3, 100);
		chk(n >= POR + 18 && n <= POR + 20, 1'b1);
		rd(OPCODE_ADDR);
		chk(q, 32'h09);
		wr(OPCODE_ADDR, 8'hff);
		wr(OPCODE_ADDR, OP_STOP);
		hold(2, 9500);
		chk(n >= 8400 && core_reset, 1'b1);
		close_out;
	end
endmodule
